// *** psfm_board.sv ***
`timescale 1ns/1ps
// ====
// board straps, external radio, codec and host levels
module psfm_board
(
  input wire logic strap_phase_i,
  input wire logic [15:0] pulldown_i,
  input wire logic [3:0] rf_pulldown_i,
  input wire logic [15:0] ext_i,
  input wire logic [3:0] rf_ext_i,
  input wire logic [15:0] gpio_out_i,
  input wire logic [15:0] gpio_oe_i,
  input wire logic [3:0] rf_out_i,
  input wire logic [3:0] rf_oe_i,
  output logic [15:0] gpio_in_o,
  output logic [3:0] rf_in_o
);
  always_comb
  begin
    // a resistor only wins while no party drives the pad; an unloaded pad floats high
    gpio_in_o = strap_phase_i ? ~pulldown_i : ext_i;
    rf_in_o = strap_phase_i ? ~rf_pulldown_i : rf_ext_i;
    gpio_in_o = (gpio_oe_i & gpio_out_i) | (~gpio_oe_i & gpio_in_o);
    rf_in_o = (rf_oe_i & rf_out_i) | (~rf_oe_i & rf_in_o);
  end
endmodule

// *** psfm_pkg.sv ***
package psfm_pkg;
  localparam int unsigned PSFM_NGPIO = 16;
  localparam logic [3:0] PSFM_ADDR_MODE = 4'h0;
  localparam logic [3:0] PSFM_ADDR_STRAP = 4'h1;
  localparam logic [3:0] PSFM_ADDR_GPIO_OUT = 4'h2;
  localparam logic [3:0] PSFM_ADDR_GPIO_OE = 4'h3;
  localparam logic [3:0] PSFM_ADDR_GPIO_IN = 4'h4;
  localparam logic [3:0] PSFM_ADDR_FUNC = 4'h5;
  localparam logic [3:0] PSFM_ADDR_STATUS = 4'h6;
  localparam int unsigned PSFM_MODE_UART = 0;
  localparam int unsigned PSFM_MODE_AUDIO = 1;
  localparam int unsigned PSFM_MODE_COEX = 2;
  localparam int unsigned PSFM_MODE_JTAG = 3;
  localparam int unsigned PSFM_MODE_OSC = 4;
  localparam int unsigned PSFM_MODE_RF = 5;
  localparam int unsigned PSFM_MODE_SDIO4 = 6;
  localparam int unsigned PSFM_MODE_AMASTER = 7;
  localparam int unsigned PSFM_MODE_ASWAP = 8;
  localparam int unsigned PSFM_MODE_CCLK = 9;
  localparam int unsigned PSFM_MODE_PRI2 = 10;
  localparam logic [15:0] PSFM_MODE_RST = 16'h0000;
  localparam logic [15:0] PSFM_GPIO_RST = 16'h0000;
  localparam logic [9:0] PSFM_STRAP_RST = 10'h3ff;
  localparam int unsigned PSFM_STRAP_HOST0 = 0;
  localparam int unsigned PSFM_STRAP_HOST1 = 1;
  localparam int unsigned PSFM_STRAP_CLK = 5;
  localparam int unsigned PSFM_STRAP_RSV6 = 6;
  localparam real PSFM_REF_MHZ_SEL1 = 26.0;
  localparam real PSFM_REF_MHZ_SEL0 = 40.0;
  localparam real PSFM_SLEEP_KHZ = 32.768;
  typedef struct packed {
    logic [15:0] dout;
    logic [15:0] oe;
  } psfm_pad_s;
  typedef struct packed {
    logic rx;
    logic cts_n;
    logic dsr_n;
    logic req;
    logic pri;
    logic dir;
    logic overlap;
    logic tck;
    logic tms;
    logic tdi;
    logic bclk;
    logic sync;
    logic adin;
  } psfm_fin_s;
endpackage

// *** psfm_top.sv ***
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module psfm_top
  import psfm_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic power_down_in_n_i,
  input wire logic [15:0] gpio_in_i,
  input wire logic [3:0] rf_pad_in_i,
  input wire logic sleep_clock_in_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic [15:0] gpio_out_o,
  output logic [15:0] gpio_oe_o,
  output logic [3:0] rf_pad_out_o,
  output logic [3:0] rf_pad_oe_o,
  output logic [3:0] sdio_dat_role_o,
  output logic ref_clk_26m_o,
  output logic host_sdio_uart_o,
  output logic powered_down_o,
  output logic [12:0] func_in_o,
  input wire logic [9:0] func_out_i
);
  // func_out_i: tx, rts_n, dtr_n, grant, tdo, bclk, sync, adout, cclk, osc_en
  // ==========================================
  // input synchronisers
  logic [15:0] gpio_m, gpio_s;
  logic [3:0] rf_m, rf_s;
  logic pd_m, pd_s, pd_q, slp_m, slp_s;
  always_ff @(posedge clk_i)
  begin
    gpio_m <= gpio_in_i;
    gpio_s <= gpio_m;
    rf_m <= rf_pad_in_i;
    rf_s <= rf_m;
    pd_m <= power_down_in_n_i;
    pd_s <= pd_m;
    slp_m <= sleep_clock_in_i;
    slp_s <= slp_m;
    pd_q <= pd_s;
  end
  // ==========================================
  // internal reset: pin reset or power-down held low
  // a low-to-high on power-down gives one more reset cycle, so straps relatch
  logic rst_n, in_reset;
  assign rst_n = resetn_i && pd_s && pd_q;
  always_ff @(posedge clk_i)
  begin
    in_reset <= !rst_n;
  end
  // ==========================================
  // strap latch
  logic [9:0] strap, next_strap;
  always_comb
  begin
    next_strap = strap;
    if (in_reset && rst_n)
    begin
      // unloaded pads idle high through the weak pull-ups, so open reads 1
      next_strap[0] = rf_s[0];
      next_strap[1] = rf_s[2];
      next_strap[6] = rf_s[1];
      next_strap[5] = rf_s[3];
      next_strap[7] = gpio_s[8];
      next_strap[8] = gpio_s[11];
      next_strap[9] = gpio_s[1];
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (!rst_n)
      strap <= PSFM_STRAP_RST;
    else
      strap <= next_strap;
  end
  // ==========================================
  // registers
  logic [15:0] mode, next_mode, gout, next_gout, goe, next_goe;
  always_comb
  begin
    next_mode = mode;
    next_gout = gout;
    next_goe = goe;
    if (reg_wr_i)
    begin
      unique case (reg_addr_i)
        PSFM_ADDR_MODE: next_mode = reg_wdata_i[15:0];
        PSFM_ADDR_GPIO_OUT: next_gout = reg_wdata_i[15:0];
        PSFM_ADDR_GPIO_OE: next_goe = reg_wdata_i[15:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (!rst_n)
    begin
      mode <= PSFM_MODE_RST;
      gout <= PSFM_GPIO_RST;
      goe <= PSFM_GPIO_RST;
    end
    else
    begin
      mode <= next_mode;
      gout <= next_gout;
      goe <= next_goe;
    end
  end
  logic [31:0] next_rdata;
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        PSFM_ADDR_MODE: next_rdata = {16'h0000, mode};
        PSFM_ADDR_STRAP: next_rdata = {22'h000000, strap};
        PSFM_ADDR_GPIO_OUT: next_rdata = {16'h0000, gout};
        PSFM_ADDR_GPIO_OE: next_rdata = {16'h0000, goe};
        PSFM_ADDR_GPIO_IN: next_rdata = {16'h0000, gpio_s};
        PSFM_ADDR_FUNC: next_rdata = {22'h000000, func_out_i};
        PSFM_ADDR_STATUS: next_rdata = {29'h00000000, slp_s, !rst_n, strap[PSFM_STRAP_CLK]};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      reg_rdata_o <= 32'h0000_0000;
    else
      reg_rdata_o <= next_rdata;
  end
  // ==========================================
  // pad mux
  logic m_uart, m_aud, m_coex, m_jtag, m_osc, m_rf, m_ams, m_swap, m_cclk;
  assign m_uart = mode[PSFM_MODE_UART];
  assign m_aud = mode[PSFM_MODE_AUDIO];
  assign m_coex = mode[PSFM_MODE_COEX] && !m_aud;
  assign m_jtag = mode[PSFM_MODE_JTAG];
  assign m_osc = mode[PSFM_MODE_OSC] && slp_s;
  assign m_rf = mode[PSFM_MODE_RF];
  assign m_ams = mode[PSFM_MODE_AMASTER];
  assign m_swap = mode[PSFM_MODE_ASWAP];
  assign m_cclk = mode[PSFM_MODE_CCLK] && m_ams;
  psfm_pad_s next_pad;
  always_comb
  begin
    next_pad.dout = gout;
    next_pad.oe = goe;
    if (m_osc)
    begin
      next_pad.dout[0] = func_out_i[0];
      next_pad.oe[0] = 1'b1;
    end
    if (m_uart)
    begin
      next_pad.oe[9] = 1'b0;
      next_pad.dout[10] = func_out_i[9];
      next_pad.oe[10] = 1'b1;
      next_pad.dout[11] = func_out_i[8];
      next_pad.oe[11] = 1'b1;
      next_pad.oe[8] = 1'b0;
      next_pad.dout[13] = func_out_i[7];
      next_pad.oe[13] = 1'b1;
      next_pad.oe[12] = 1'b0;
    end
    if (m_coex)
    begin
      next_pad.oe[7] = 1'b0;
      next_pad.dout[5] = func_out_i[6];
      next_pad.oe[5] = 1'b1;
      next_pad.oe[6] = 1'b0;
      next_pad.oe[4] = 1'b0;
      next_pad.oe[1] = 1'b0;
    end
    if (m_aud)
    begin
      next_pad.dout[6] = func_out_i[4];
      next_pad.oe[6] = m_ams;
      next_pad.dout[7] = func_out_i[3];
      next_pad.oe[7] = m_ams;
      next_pad.dout[4] = func_out_i[2];
      next_pad.oe[4] = !m_swap;
      next_pad.dout[5] = func_out_i[2];
      next_pad.oe[5] = m_swap;
      if (m_cclk)
      begin
        next_pad.dout[3] = func_out_i[1];
        next_pad.oe[3] = 1'b1;
      end
    end
    if (m_jtag)
    begin
      next_pad.dout[3] = func_out_i[5];
      next_pad.oe[3] = 1'b1;
      next_pad.oe[2] = 1'b0;
      next_pad.oe[15] = 1'b0;
      next_pad.oe[14] = 1'b0;
    end
  end
  psfm_fin_s next_fin;
  always_comb
  begin
    next_fin.rx = m_uart ? gpio_s[9] : 1'b1;
    next_fin.cts_n = m_uart ? gpio_s[8] : 1'b1;
    next_fin.dsr_n = m_uart ? gpio_s[12] : 1'b1;
    next_fin.req = m_coex && gpio_s[7];
    next_fin.pri = m_coex && gpio_s[6];
    next_fin.dir = m_coex && gpio_s[1];
    next_fin.overlap = m_coex && gpio_s[4];
    next_fin.tck = m_jtag && gpio_s[14];
    next_fin.tms = m_jtag && gpio_s[15];
    next_fin.tdi = m_jtag && gpio_s[2];
    next_fin.bclk = m_aud && gpio_s[6];
    next_fin.sync = m_aud && gpio_s[7];
    next_fin.adin = m_aud && (m_swap ? gpio_s[4] : gpio_s[5]);
  end
  logic [3:0] next_rf_out, next_rf_oe, next_dat;
  always_comb
  begin
    // reset: rf pads are not driven (oe low); pre-firmware: rf pads are outputs at their inactive level
    next_rf_out = m_rf ? func_out_i[3:0] ^ 4'h5 : 4'h5;
    next_rf_oe = in_reset ? 4'h0 : 4'hf;
    // roles: 0 data, 1 interrupt, 2 read wait, 3 reserved
    next_dat = mode[PSFM_MODE_SDIO4] ? 4'h0 : 4'h6;
  end
  always_ff @(posedge clk_i)
  begin
    if (!rst_n)
    begin
      gpio_out_o <= PSFM_GPIO_RST;
      gpio_oe_o <= PSFM_GPIO_RST;
      rf_pad_out_o <= 4'h0;
      rf_pad_oe_o <= 4'h0;
      sdio_dat_role_o <= 4'h6;
      ref_clk_26m_o <= 1'b1;
      host_sdio_uart_o <= 1'b0;
      func_in_o <= 13'h0000;
      powered_down_o <= 1'b1;
    end
    else
    begin
      gpio_out_o <= next_pad.dout;
      gpio_oe_o <= next_pad.oe;
      rf_pad_out_o <= next_rf_out;
      rf_pad_oe_o <= next_rf_oe;
      sdio_dat_role_o <= next_dat;
      ref_clk_26m_o <= strap[PSFM_STRAP_CLK];
      host_sdio_uart_o <= strap[PSFM_STRAP_HOST1] && !strap[PSFM_STRAP_HOST0];
      func_in_o <= next_fin;
      powered_down_o <= 1'b0;
    end
  end
  // ==========================================
  // checks
  // power-down release takes two steps: the pin rises, then one extra reset cycle
  sequence psfm_pd_rise_seq;
    $rose(pd_s);
  endsequence
  sequence psfm_one_extra_reset_seq;
    powered_down_o ##1 !powered_down_o;
  endsequence
  // the strap capture edge is the only cycle with both flags set
  sequence psfm_release_seq;
    in_reset && rst_n;
  endsequence

  AST_PD_RESET: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !pd_s |=> powered_down_o)
    else $error("power-down not held");
  AST_PD_EXTRA: assert property (@(posedge clk_i) disable iff (!resetn_i)
    psfm_pd_rise_seq |=> psfm_one_extra_reset_seq)
    else $error("power-down release not one extra reset cycle");
  AST_POWERED: assert property (@(posedge clk_i) disable iff (!rst_n)
    1'b1 |=> !powered_down_o)
    else $error("powered down flag set while running");
  AST_STRAP_RESET: assert property (@(posedge clk_i)
    !rst_n |=> strap == PSFM_STRAP_RST)
    else $error("strap not preset to ones in reset");
  AST_STRAP_CAPTURE: assert property (@(posedge clk_i) disable iff (!rst_n)
    psfm_release_seq |=> strap[0] == $past(rf_s[0]) && strap[1] == $past(rf_s[2])
      && strap[6] == $past(rf_s[1]) && strap[5] == $past(rf_s[3]))
    else $error("strap not captured at release");
  AST_STRAP_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n)
    !in_reset |=> $stable(strap))
    else $error("strap changed after release");
  AST_RF_OE_RESET: assert property (@(posedge clk_i) disable iff (!rst_n)
    psfm_release_seq |=> rf_pad_oe_o == 4'h0)
    else $error("rf pads driven during strap capture");
  AST_RF_OE_RUN: assert property (@(posedge clk_i) disable iff (!rst_n)
    !in_reset |=> rf_pad_oe_o == 4'hf)
    else $error("rf pads not driven after release");
  AST_CLK_SEL: assert property (@(posedge clk_i) disable iff (!rst_n)
    !in_reset |=> ref_clk_26m_o == $past(strap[PSFM_STRAP_CLK]))
    else $error("clock select wrong");
  AST_HOST: assert property (@(posedge clk_i) disable iff (!rst_n)
    1'b1 |=> host_sdio_uart_o == ($past(strap[1]) && !$past(strap[0])))
    else $error("host select wrong");
  AST_STRAP_READ: assert property (@(posedge clk_i) disable iff (!rst_n)
    reg_rd_i && reg_addr_i == PSFM_ADDR_STRAP |=> reg_rdata_o == {22'h000000, $past(strap)})
    else $error("strap read back wrong");
  AST_RF_LVL: assert property (@(posedge clk_i) disable iff (!rst_n)
    !m_rf && !in_reset |=> rf_pad_out_o == 4'h5)
    else $error("rf idle level wrong");
  AST_RF_FUNC: assert property (@(posedge clk_i) disable iff (!rst_n)
    m_rf |=> rf_pad_out_o == ($past(func_out_i[3:0]) ^ 4'h5))
    else $error("rf functional polarity wrong");
  AST_SDIO1: assert property (@(posedge clk_i) disable iff (!rst_n)
    !mode[PSFM_MODE_SDIO4] |=> sdio_dat_role_o == 4'h6)
    else $error("sdio 1-bit roles wrong");
  AST_SDIO4: assert property (@(posedge clk_i) disable iff (!rst_n)
    mode[PSFM_MODE_SDIO4] |=> sdio_dat_role_o == 4'h0)
    else $error("sdio 4-bit roles wrong");

  AST_UART_TX: assert property (@(posedge clk_i) disable iff (!rst_n)
    m_uart |=> gpio_oe_o[10] && gpio_out_o[10] == $past(func_out_i[9]))
    else $error("uart tx not routed");
  AST_UART_RTS: assert property (@(posedge clk_i) disable iff (!rst_n)
    m_uart |=> gpio_oe_o[11] && gpio_out_o[11] == $past(func_out_i[8])
      && !gpio_oe_o[9] && !gpio_oe_o[8])
    else $error("uart rts or inputs not routed");
  AST_UART_IN: assert property (@(posedge clk_i) disable iff (!rst_n)
    m_uart |=> func_in_o[12] == $past(gpio_s[9]) && func_in_o[11] == $past(gpio_s[8]))
    else $error("uart rx or cts not routed");
  AST_DTR: assert property (@(posedge clk_i) disable iff (!rst_n)
    m_uart |=> gpio_oe_o[13] && gpio_out_o[13] == $past(func_out_i[7])
      && !gpio_oe_o[12] && func_in_o[10] == $past(gpio_s[12]))
    else $error("modem lines not routed");
  AST_GRANT: assert property (@(posedge clk_i) disable iff (!rst_n)
    m_coex |=> gpio_oe_o[5] && !gpio_oe_o[7])
    else $error("coex pads wrong");
  AST_GRANT_OUT: assert property (@(posedge clk_i) disable iff (!rst_n)
    m_coex |=> gpio_out_o[5] == $past(func_out_i[6]))
    else $error("grant not routed");
  AST_COEX_IN: assert property (@(posedge clk_i) disable iff (!rst_n)
    m_coex |=> func_in_o[9] == $past(gpio_s[7]) && func_in_o[8] == $past(gpio_s[6])
      && func_in_o[7] == $past(gpio_s[1]) && func_in_o[6] == $past(gpio_s[4]))
    else $error("coex inputs not routed");
  AST_AUD_DIR: assert property (@(posedge clk_i) disable iff (!rst_n)
    m_aud |=> gpio_oe_o[4] != gpio_oe_o[5])
    else $error("audio data both same");
  AST_AUD_SWAP: assert property (@(posedge clk_i) disable iff (!rst_n)
    m_aud && m_swap |=> gpio_oe_o[5] && gpio_out_o[5] == $past(func_out_i[2])
      && func_in_o[0] == $past(gpio_s[4]))
    else $error("swapped audio data wrong");
  AST_AUD_MASTER: assert property (@(posedge clk_i) disable iff (!rst_n)
    m_aud && m_ams |=> gpio_oe_o[6] && gpio_oe_o[7]
      && gpio_out_o[6] == $past(func_out_i[4]) && gpio_out_o[7] == $past(func_out_i[3]))
    else $error("audio master clocks not driven");
  AST_AUD_SLAVE: assert property (@(posedge clk_i) disable iff (!rst_n)
    m_aud && !m_ams |=> !gpio_oe_o[6] && !gpio_oe_o[7]
      && func_in_o[2] == $past(gpio_s[6]) && func_in_o[1] == $past(gpio_s[7]))
    else $error("audio slave clocks not taken");
  AST_CCLK: assert property (@(posedge clk_i) disable iff (!rst_n)
    m_aud && m_cclk && !m_jtag |=> gpio_oe_o[3] && gpio_out_o[3] == $past(func_out_i[1]))
    else $error("codec clock not driven");
  AST_JTAG: assert property (@(posedge clk_i) disable iff (!rst_n)
    m_jtag |=> gpio_oe_o[3] && !gpio_oe_o[2] && !gpio_oe_o[15])
    else $error("test port pads wrong");
  AST_JTAG_IO: assert property (@(posedge clk_i) disable iff (!rst_n)
    m_jtag |=> gpio_out_o[3] == $past(func_out_i[5]) && func_in_o[5] == $past(gpio_s[14])
      && func_in_o[4] == $past(gpio_s[15]) && func_in_o[3] == $past(gpio_s[2]))
    else $error("test port signals not routed");
  AST_OSC: assert property (@(posedge clk_i) disable iff (!rst_n)
    !slp_s && !m_jtag && !m_aud |=> gpio_out_o[0] == $past(gout[0]))
    else $error("osc enable without sleep clock");
  AST_OSC_ON: assert property (@(posedge clk_i) disable iff (!rst_n)
    m_osc |=> gpio_oe_o[0] && gpio_out_o[0] == $past(func_out_i[0]))
    else $error("osc enable not driven");

  // pads keep plain gpio behaviour until software picks a role
  AST_GPIO_DEFAULT: assert property (@(posedge clk_i) disable iff (!rst_n)
    mode == PSFM_MODE_RST |=> gpio_oe_o == $past(goe) && gpio_out_o == $past(gout))
    else $error("pads left gpio mode without a mode write");
  AST_MODE_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n)
    !(reg_wr_i && reg_addr_i == PSFM_ADDR_MODE) |=> $stable(mode))
    else $error("mode changed without a write");
  AST_MODE_WRITE: assert property (@(posedge clk_i) disable iff (!rst_n)
    reg_wr_i && reg_addr_i == PSFM_ADDR_MODE |=> mode == $past(reg_wdata_i[15:0]))
    else $error("mode write lost");
endmodule

// *** tb_pin_strap_and_function_mux.sv ***
`timescale 1ns/1ps
module tb_pin_strap_and_function_mux
  import psfm_pkg::*;
;
  typedef struct {int sel; logic [31:0] exp; logic [31:0] msk;} psfm_note_s;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic pd_n = 1'b1;
  logic slp = 1'b0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic look = 1'b0;
  logic strap_ph = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [3:0] rf_ext = 4'h0;
  logic [3:0] rf_pd = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [9:0] fo = 10'h0;
  logic [15:0] ext = 16'h0;
  logic [15:0] pulld = 16'h0;
  logic [9:0] strap;
  logic [15:0] gpio_in, gpio_out, gpio_oe;
  logic [3:0] rf_in, rf_out, rf_oe, sdio_role;
  logic [31:0] rdata;
  logic [12:0] fin;
  logic ref26, host, pdo;
  int fails = 0;
  int tests_run = 0;
  psfm_note_s q[$];

  psfm_top i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .power_down_in_n_i(pd_n),
    .gpio_in_i(gpio_in), .rf_pad_in_i(rf_in), .sleep_clock_in_i(slp), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
    .gpio_out_o(gpio_out), .gpio_oe_o(gpio_oe), .rf_pad_out_o(rf_out), .rf_pad_oe_o(rf_oe),
    .sdio_dat_role_o(sdio_role), .ref_clk_26m_o(ref26), .host_sdio_uart_o(host),
    .powered_down_o(pdo), .func_in_o(fin), .func_out_i(fo));
  psfm_board i_board (.strap_phase_i(strap_ph), .pulldown_i(pulld), .rf_pulldown_i(rf_pd),
    .ext_i(ext), .rf_ext_i(rf_ext), .gpio_out_i(gpio_out), .gpio_oe_i(gpio_oe),
    .rf_out_i(rf_out), .rf_oe_i(rf_oe), .gpio_in_o(gpio_in), .rf_in_o(rf_in));

  initial forever #2 clk_i = ~clk_i;

  // ====
  // checks: the driver notes, this process compares in the flagged cycle
  always @(negedge clk_i)
    if (look)
    begin
      psfm_note_s n;
      logic [31:0] got;
      n = q.pop_front();
      case (n.sel)
        0: got = rdata;
        1: got = {gpio_oe, gpio_out & gpio_oe};
        2: got = 32'(fin);
        default: got = {17'h0, rf_oe, rf_out, sdio_role, ref26, host, pdo};
      endcase
      tests_run++;
      if ((got & n.msk) !== (n.exp & n.msk))
      begin
        fails++;
        $display("CHECK FAILED t=%0t exp=%h got=%h", $time, n.exp & n.msk, got & n.msk);
      end
    end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic note(input int s, input logic [31:0] e, input logic [31:0] m);
    q.push_back('{s, e, m});
    look <= 1'b1;
    @(posedge clk_i);
    look <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk_i);
    wr_s <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_i);
    rd_s <= 1'b0;
    note(0, e, 32'hffffffff);
  endtask

  // straps stay on the pads for several cycles after release; the latch must ignore later changes
  task automatic do_reset(input logic use_pd, input logic [3:0] rpd, input logic [15:0] gpd);
    rf_pd <= rpd;
    pulld <= gpd;
    strap_ph <= 1'b1;
    if (use_pd)
      pd_n <= 1'b0;
    else
      resetn_i <= 1'b0;
    strap = 10'h3ff & ~{gpd[1], gpd[11], gpd[8], rpd[1], rpd[3], 3'b000, rpd[2], rpd[0]};
    repeat (12) @(posedge clk_i);
    note(3, {17'h0, 8'h00, 4'h6, 3'b101}, 32'h7fff);
    if (use_pd)
      pd_n <= 1'b1;
    else
      resetn_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    strap_ph <= 1'b0;
    rf_ext <= 4'($urandom);
    ext <= 16'($urandom);
    @(posedge clk_i);
    note(3, {17'h0, 8'hf5, 4'h6, strap[5], strap[1] & ~strap[0], 1'b0}, 32'h7fff);
    rd(PSFM_ADDR_STRAP, {22'h0, strap});
  endtask

  function automatic logic [31:0] exp_pad(input logic [15:0] m);
    logic [15:0] oe;
    logic [15:0] o;
    oe = 16'h0;
    o = 16'h0;
    if (m[0])
    begin
      oe[13:10] = 4'hb;
      o[13:10] = {fo[7], 1'b0, fo[8], fo[9]};
    end
    if (m[2] && !m[1])
    begin
      oe[5] = 1'b1;
      o[5] = fo[6];
    end
    if (m[1])
    begin
      oe[m[8] ? 5 : 4] = 1'b1;
      o[m[8] ? 5 : 4] = fo[2];
      oe[7:6] = {2{m[7]}};
      o[7:6] = {fo[3], fo[4]};
      oe[3] = m[9] & m[7];
      o[3] = fo[1];
    end
    if (m[3])
    begin
      oe[3] = 1'b1;
      o[3] = fo[5];
    end
    if (m[4] && slp)
    begin
      oe[0] = 1'b1;
      o[0] = fo[0];
    end
    return {oe, o & oe};
  endfunction

  // ====
  // stimulus
  initial
  begin
    logic [15:0] modes [11];
    logic [15:0] m;
    logic [12:0] fe;
    logic [12:0] fm;
    logic [31:0] gv;
    modes = '{16'h000d, 16'h0002, 16'h0082, 16'h0382, 16'h0010, 16'h0010, 16'h0006,
      16'h028a, 16'h0060, 16'h0400, 16'h0000};
    void'($urandom(32'h313ce1a5));
    for (int i = 0; i < 4; i++)
      do_reset(i[0], (i == 1) ? 4'h1 : 4'($urandom), 16'($urandom));
    for (int i = 0; i < 11; i++)
    begin
      m = modes[i];
      wr(PSFM_ADDR_MODE, {16'h0, m});
      fo <= 10'($urandom);
      ext <= 16'($urandom);
      slp <= i[0];
      repeat (4) @(posedge clk_i);
      fe = {ext[9], ext[8], ext[12], ext[7], ext[6], ext[1], ext[4], ext[14], ext[15],
        ext[2], ext[6], ext[7], m[8] ? ext[4] : ext[5]};
      fm = {{3{m[0]}}, {4{m[2] & ~m[1]}}, {3{m[3]}}, {2{m[1] & ~m[7]}}, m[1]};
      note(1, exp_pad(m), 32'hffffffff);
      note(2, 32'(fe), 32'(fm));
      note(3, {17'h0, 4'hf, m[5] ? fo[3:0] ^ 4'h5 : 4'h5, m[6] ? 4'h0 : 4'h6, 3'b0},
        32'h7ff8);
      rd(PSFM_ADDR_MODE, {16'h0, m});
      rd(PSFM_ADDR_FUNC, {22'h0, fo});
    end
    gv = $urandom;
    wr(PSFM_ADDR_GPIO_OUT, {16'h0, gv[15:0]});
    wr(PSFM_ADDR_GPIO_OE, {16'h0, gv[31:16]});
    repeat (4) @(posedge clk_i);
    note(1, {gv[31:16], gv[15:0] & gv[31:16]}, 32'hffffffff);
    rd(PSFM_ADDR_GPIO_IN, {16'h0, (gv[31:16] & gv[15:0]) | (~gv[31:16] & ext)});
    wr(4'hf, $urandom);
    rd(4'hf, 32'h0);
    wr(PSFM_ADDR_STRAP, 32'h0);
    rd(PSFM_ADDR_STRAP, {22'h0, strap});
    rd(PSFM_ADDR_GPIO_OE, {16'h0, gv[31:16]});
    end_of_test();
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    fails++;
    end_of_test();
  end
endmodule
